/* File: common/ceg_pkg.sv */
// constants for the converter four enable gating block
// assumes a 250 MHz core clock and the device's own register port
package ceg_pkg;

  // register offsets
  localparam logic [7:0] CEG_OFS_MASK_A = 8'h10;
  localparam logic [7:0] CEG_OFS_SRC_MASK_B = 8'h11;
  localparam logic [7:0] CEG_OFS_EDGE_DLY = 8'h12;

  // values after reset
  localparam logic [7:0] CEG_RST_MASK_A = 8'h00;
  localparam logic [7:0] CEG_RST_SRC_MASK_B = 8'h80;
  localparam logic [7:0] CEG_RST_EDGE_DLY = 8'h00;

  // field positions in the first register
  localparam int CEG_BIT_AUX_LDO_THREE = 7;
  localparam int CEG_BIT_AUX_LDO_TWO = 6;
  localparam int CEG_BIT_SWITCH_A_ONE = 5;
  localparam int CEG_BIT_CONV_SIX = 4;
  localparam int CEG_BIT_CONV_FIVE = 3;
  localparam int CEG_BIT_CONV_THREE = 2;
  localparam int CEG_BIT_CONV_TWO = 1;
  localparam int CEG_BIT_CONV_ONE = 0;

  // field positions in the second register
  localparam int CEG_BIT_SHARED_RAIL = 1;
  localparam int CEG_BIT_SWITCH_B_ONE = 0;
  localparam int CEG_SRC_LSB = 2;
  localparam int CEG_SRC_MSB = 4;

  // field positions in the third register
  localparam int CEG_ON_DLY_LSB = 0;
  localparam int CEG_ON_DLY_MSB = 2;
  localparam int CEG_OFF_DLY_LSB = 3;
  localparam int CEG_OFF_DLY_MSB = 5;

  // enable source codes
  typedef enum logic [2:0] {
    CEG_SRC_CONTROL_INPUT_1 = 3'h0,
    CEG_SRC_CONTROL_INPUT_2 = 3'h1,
    CEG_SRC_CONTROL_INPUT_5 = 3'h2,
    CEG_SRC_CONTROL_INPUT_4 = 3'h3,
    CEG_SRC_CONTROL_INPUT_3 = 3'h4,
    CEG_SRC_CONTROL_INPUT_3_AND_4 = 3'h5,
    CEG_SRC_CONTROL_INPUT_6 = 3'h6,
    CEG_SRC_ALWAYS = 3'h7
  } ceg_src_t;

  // timing: clock period in ps, one millisecond in ps, cycles per ms
  localparam int CEG_CLK_PERIOD_PS = 4000;
  localparam int CEG_MS_IN_PS = 1000000000;
  localparam int CEG_MS_CYCLES = CEG_MS_IN_PS / CEG_CLK_PERIOD_PS;
  localparam int CEG_CNT_W = 24;

  // delay code to milliseconds
  function automatic int ceg_dly_ms(input logic [2:0] code);
    int ms;
    ms = 0;
    case (code)
      3'h1: ms = 2;
      3'h2: ms = 4;
      3'h3: ms = 8;
      3'h4: ms = 16;
      3'h5: ms = 24;
      3'h6: ms = 32;
      3'h7: ms = 64;
      default: ms = 0;
    endcase
    return ms;
  endfunction

endpackage

/* File: rtl/ceg_edge_delay.sv */
// edge delay stage: holds off each change of the enable by its own count
// assumes counts already converted to cycles by the caller
`timescale 1ns/100ps
`default_nettype none

module ceg_edge_delay
  import ceg_pkg::*;
#(
  parameter int CNT_W = CEG_CNT_W
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // enable request and delays in cycles
  input wire logic en_req,
  input wire logic [CNT_W-1:0] rise_cycles,
  input wire logic [CNT_W-1:0] fall_cycles,
  // delayed enable
  output logic en_out
);

  typedef struct packed {
    logic out;
    logic [CNT_W-1:0] cnt;
  } ceg_dly_state_t;

  ceg_dly_state_t s_q;
  ceg_dly_state_t s_d;
  logic [CNT_W-1:0] limit;

  ////////////////////////////////////////////////////////////////////////
  // a short glitch against the current level restarts the count
  always_comb
  begin
    s_d = s_q;
    limit = s_q.out ? fall_cycles : rise_cycles;
    if (en_req == s_q.out)
    begin
      s_d.cnt = '0;
    end
    else if (s_q.cnt >= limit)
    begin
      s_d.out = en_req;
      s_d.cnt = '0;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign en_out = s_q.out;

endmodule

`default_nettype wire

/* File: rtl/ceg_top.sv */
// converter four enable gating: source select, power-good masks, edge delays
// assumes control inputs and power-good levels synchronous to core_clk
//
// Behaviour
// - mask bits 7..5 drop aux and switch goods
// - mask bits 4..0 drop converter goods
// - second register bits 1..0 drop more goods
// - source field bits 4:2 picks control input
// - source code 111 forces pin term true
// - turn-on delay code in bits 2:0
// - turn-off delay code in bits 5:3
`timescale 1ns/100ps
`default_nettype none

module ceg_top
  import ceg_pkg::*;
#(
  parameter int MS_CYCLES = CEG_MS_CYCLES,
  parameter int CNT_W = CEG_CNT_W
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // control inputs
  input wire logic control_input_1,
  input wire logic control_input_2,
  input wire logic control_input_3,
  input wire logic control_input_4,
  input wire logic control_input_5,
  input wire logic control_input_6,
  // power-good of other rails
  input wire logic aux_ldo_three_power_good,
  input wire logic aux_ldo_two_power_good,
  input wire logic load_switch_a_one_power_good,
  input wire logic converter_six_power_good,
  input wire logic converter_five_power_good,
  input wire logic converter_three_power_good,
  input wire logic converter_two_power_good,
  input wire logic converter_one_power_good,
  input wire logic shared_switch_regulator_rail_power_good,
  input wire logic load_switch_b_one_power_good,
  // converter control
  output logic converter_four_enable,
  output logic enable_request
);

  typedef struct packed {
    logic [7:0] mask_a;
    logic [7:0] src_mask_b;
    logic [7:0] edge_dly;
    logic [7:0] rdata;
    logic req;
  } ceg_state_t;

  // ten power-good terms feed the AND
  localparam int GOODS_N = 10;

  ceg_state_t s_q;
  ceg_state_t s_d;
  ceg_src_t src;
  logic pin_term;
  logic [GOODS_N-1:0] good_in;
  logic [GOODS_N-1:0] good_mask;
  wire [GOODS_N-1:0] good_pass;
  logic goods_ok;
  logic [2:0] on_code;
  logic [2:0] off_code;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [CNT_W-1:0] rise_cycles;
  logic [CNT_W-1:0] fall_cycles;
  logic dly_out;

  ////////////////////////////////////////////////////////////////////////
  // power-good levels and their mask bits, in the same bit order
  assign good_in = {
    aux_ldo_three_power_good,
    aux_ldo_two_power_good,
    load_switch_a_one_power_good,
    converter_six_power_good,
    converter_five_power_good,
    converter_three_power_good,
    converter_two_power_good,
    converter_one_power_good,
    shared_switch_regulator_rail_power_good,
    load_switch_b_one_power_good
  };
  assign good_mask = {
    s_q.mask_a[CEG_BIT_AUX_LDO_THREE],
    s_q.mask_a[CEG_BIT_AUX_LDO_TWO],
    s_q.mask_a[CEG_BIT_SWITCH_A_ONE],
    s_q.mask_a[CEG_BIT_CONV_SIX],
    s_q.mask_a[CEG_BIT_CONV_FIVE],
    s_q.mask_a[CEG_BIT_CONV_THREE],
    s_q.mask_a[CEG_BIT_CONV_TWO],
    s_q.mask_a[CEG_BIT_CONV_ONE],
    s_q.src_mask_b[CEG_BIT_SHARED_RAIL],
    s_q.src_mask_b[CEG_BIT_SWITCH_B_ONE]
  };

  // a set mask bit forces its good true, so it drops out of the AND
  // goods are taken as they stand; no filtering of a bouncing good
  for (genvar g = 0; g < GOODS_N; g++)
  begin : g_good
    assign good_pass[g] = good_in[g] | good_mask[g];
  end

  ////////////////////////////////////////////////////////////////////////
  // source select and the gated AND
  always_comb
  begin
    src = ceg_src_t'(s_q.src_mask_b[CEG_SRC_MSB:CEG_SRC_LSB]);
    unique case (src)
      CEG_SRC_CONTROL_INPUT_1: pin_term = control_input_1;
      CEG_SRC_CONTROL_INPUT_2: pin_term = control_input_2;
      CEG_SRC_CONTROL_INPUT_5: pin_term = control_input_5;
      CEG_SRC_CONTROL_INPUT_4: pin_term = control_input_4;
      CEG_SRC_CONTROL_INPUT_3: pin_term = control_input_3;
      CEG_SRC_CONTROL_INPUT_3_AND_4: pin_term = control_input_3 & control_input_4;
      CEG_SRC_CONTROL_INPUT_6: pin_term = control_input_6;
      CEG_SRC_ALWAYS: pin_term = 1'b1;
    endcase
    goods_ok = &good_pass;
  end

  ////////////////////////////////////////////////////////////////////////
  // delay codes to cycle counts; 64 ms fits CNT_W at 250 MHz
  assign on_code = s_q.edge_dly[CEG_ON_DLY_MSB:CEG_ON_DLY_LSB];
  assign off_code = s_q.edge_dly[CEG_OFF_DLY_MSB:CEG_OFF_DLY_LSB];
  assign rise_cycles = CNT_W'(ceg_dly_ms(on_code) * MS_CYCLES);
  assign fall_cycles = CNT_W'(ceg_dly_ms(off_code) * MS_CYCLES);

  ////////////////////////////////////////////////////////////////////////
  // one-hot register select, all clear for offsets outside the block
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    unique case (addr)
      CEG_OFS_MASK_A: sel = 3'h1;
      CEG_OFS_SRC_MASK_B: sel = 3'h2;
      CEG_OFS_EDGE_DLY: sel = 3'h4;
      default: sel = 3'h0;
    endcase
    return sel;
  endfunction

  // the same decode serves both strobes, so a read and a write agree
  assign wr_sel = reg_wr ? reg_sel(reg_addr) : 3'h0;
  assign rd_sel = reg_rd ? reg_sel(reg_addr) : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // registers and gated request
  always_comb
  begin
    s_d = s_q;
    s_d.req = pin_term & goods_ok;
    // reserved bits are kept as written, so software sees them back
    if (wr_sel[0])
    begin
      s_d.mask_a = reg_wdata;
    end
    if (wr_sel[1])
    begin
      s_d.src_mask_b = reg_wdata;
    end
    if (wr_sel[2])
    begin
      s_d.edge_dly = reg_wdata;
    end
    // a read in the cycle of a write returns the old value
    if (reg_rd)
    begin
      unique case (rd_sel)
        3'h1: s_d.rdata = s_q.mask_a;
        3'h2: s_d.rdata = s_q.src_mask_b;
        3'h4: s_d.rdata = s_q.edge_dly;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q.mask_a <= CEG_RST_MASK_A;
      s_q.src_mask_b <= CEG_RST_SRC_MASK_B;
      s_q.edge_dly <= CEG_RST_EDGE_DLY;
      s_q.rdata <= 8'h00;
      s_q.req <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge delays before the converter sees the enable
  ceg_edge_delay #(
    .CNT_W(CNT_W)
  ) u_dly (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .en_req(s_q.req),
    .rise_cycles(rise_cycles),
    .fall_cycles(fall_cycles),
    .en_out(dly_out)
  );

  assign converter_four_enable = dly_out;
  assign enable_request = s_q.req;
  assign reg_rdata = s_q.rdata;

endmodule

`default_nettype wire

/* File: sim/ceg_ctl_model.sv */
// control pin source standing for the external controller
// assumes the bench changes the pattern at the falling edge
`timescale 1ns/100ps
`default_nettype none
module ceg_ctl_model (
  // pattern from bench
  input wire logic [5:0] pat,
  // control pins
  output logic [5:0] pins
);
  // plain level pins, no pull or release
  assign pins = pat;
endmodule
`default_nettype wire

/* File: sim/ceg_checker.sv */
// assertions on the enable gating top ports
// assumes binding onto ceg_top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module ceg_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // pins and goods watched
  input wire logic control_input_1,
  input wire logic control_input_3,
  input wire logic control_input_4,
  input wire logic converter_one_power_good,
  input wire logic load_switch_b_one_power_good,
  input wire logic converter_four_enable,
  input wire logic enable_request
);
  logic [7:0] sa_q, sb_q, sc_q, rv;
  logic allm;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // shadow registers, used only to predict
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      sa_q <= 8'h00;
      sb_q <= 8'h80;
      sc_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h10) sa_q <= reg_wdata;
      if (reg_addr == 8'h11) sb_q <= reg_wdata;
      if (reg_addr == 8'h12) sc_q <= reg_wdata;
    end
  assign rv = reg_addr == 8'h10 ? sa_q : reg_addr == 8'h11 ? sb_q :
    reg_addr == 8'h12 ? sc_q : 8'h00;
  assign allm = sa_q == 8'hFF && sb_q[1:0] == 2'h3;
  sequence s_en_moves;
    $changed(converter_four_enable);
  endsequence
  ////////////////////////////////////////////////////////////////
  a_rd_back: assert property (reg_rd |=> reg_rdata == $past(rv))
    else $error("read data differs from register");
  a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_src_always: assert property (sb_q[4:2] == 3'h7 && allm |=> enable_request)
    else $error("forced source not true");
  a_src_pair: assert property (sb_q[4:2] == 3'h5 && allm
    |=> enable_request == ($past(control_input_3) & $past(control_input_4)))
    else $error("paired source wrong");
  a_src_one: assert property (sb_q[4:2] == 3'h0 && allm
    |=> enable_request == $past(control_input_1))
    else $error("first source wrong");
  a_mask_a: assert property (!sa_q[0] && !converter_one_power_good |=> !enable_request)
    else $error("unmasked good ignored");
  a_mask_b: assert property (!sb_q[0] && !load_switch_b_one_power_good
    |=> !enable_request)
    else $error("unmasked second good ignored");
  a_en_zero: assert property (sc_q[5:0] == 6'h00
    && enable_request != converter_four_enable
    |=> converter_four_enable == $past(enable_request))
    else $error("undelayed enable late");
  a_en_cause: assert property (s_en_moves
    |-> converter_four_enable == $past(enable_request))
    else $error("enable moved without request");
endmodule
`default_nettype wire

/* File: sim/ceg_top_tb_top.sv */
// self-checking bench for the enable gating top
// assumes MS_CYCLES shortened to 4 cycles per ms
`timescale 1ns/100ps
`default_nettype none
module ceg_top_tb_top;
  localparam int MSC = 4;
  logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, en, req;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ma, mb, mc;
  logic [7:0] ga = 8'hFF;
  logic [1:0] gb = 2'h3;
  logic [5:0] pat = 6'h00, ctl;
  int bad_count = 0, cmp_count = 0, n;
  int dms[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  always #2 core_clk = ~core_clk;
  ceg_ctl_model u_ctl (.pat(pat), .pins(ctl));
  ceg_top #(.MS_CYCLES(MSC)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .control_input_1(ctl[0]), .control_input_2(ctl[1]),
    .control_input_3(ctl[2]), .control_input_4(ctl[3]), .control_input_5(ctl[4]),
    .control_input_6(ctl[5]), .aux_ldo_three_power_good(ga[7]),
    .aux_ldo_two_power_good(ga[6]), .load_switch_a_one_power_good(ga[5]),
    .converter_six_power_good(ga[4]), .converter_five_power_good(ga[3]),
    .converter_three_power_good(ga[2]), .converter_two_power_good(ga[1]),
    .converter_one_power_good(ga[0]), .shared_switch_regulator_rail_power_good(gb[1]),
    .load_switch_b_one_power_good(gb[0]), .converter_four_enable(en),
    .enable_request(req));
  ////////////////////////////////////////////////////////////////
  function automatic logic exp_req();
    logic p;
    case (mb[4:2])
      3'h0: p = ctl[0];
      3'h1: p = ctl[1];
      3'h2: p = ctl[4];
      3'h3: p = ctl[3];
      3'h4: p = ctl[2];
      3'h5: p = ctl[2] & ctl[3];
      3'h6: p = ctl[5];
      default: p = 1'b1;
    endcase
    return p & (&(ga | ma)) & (&(gb | mb[1:0]));
  endfunction
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge core_clk);
    reg_wr = 1'b0;
    if (a == 8'h10) ma = d;
    if (a == 8'h11) mb = d;
    if (a == 8'h12) mc = d;
  endtask
  task automatic rd(logic [7:0] a);
    logic [7:0] e;
    e = a == 8'h10 ? ma : a == 8'h11 ? mb : a == 8'h12 ? mc : 8'h00;
    @(negedge core_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk("rdata", reg_rdata, e);
  endtask
  task automatic wait_en(logic v);
    n = 0;
    do begin @(negedge core_clk); n++; end while (en !== v && n < 400);
    if (n >= 400)
    begin
      bad_count++;
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 0;
    {ma, mb, mc} = {8'h00, 8'h80, 8'h00};
    void'($urandom(56));
    for (int i = 0; i < 12; i++)
    begin
      rd(8'h10 + 8'(i % 4));
      wr(8'h10 + 8'(i % 4), 8'($urandom));
    end
    $display("register test done");
    wr(8'h12, 8'h00);
    for (int i = 0; i < 160; i++)
    begin
      wr(8'h10, i < 64 ? 8'hFF : 8'($urandom));
      wr(8'h11, {3'h0, 3'(i), i < 64 ? 2'h3 : 2'($urandom)});
      {ga, gb, pat} = {8'($urandom | $urandom), 2'($urandom | $urandom), 6'($urandom)};
      repeat (3) @(negedge core_clk);
      chk("request", req, exp_req());
      chk("enable", en, exp_req());
    end
    $display("gating test done");
    wr(8'h10, 8'hFF);
    wr(8'h11, 8'h03);
    pat = 6'h00;
    repeat (3) @(negedge core_clk);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h12, {2'h0, 3'(c), 3'(c)});
      pat = 6'h01;
      wait_en(1'b1);
      chk("rise delay", n, dms[c] * MSC + 2);
      pat = 6'h00;
      wait_en(1'b0);
      chk("fall delay", n, dms[c] * MSC + 2);
    end
    wr(8'h12, 8'h01);
    pat = 6'h01;
    repeat (4) @(negedge core_clk);
    pat = 6'h00;
    repeat (2) @(negedge core_clk);
    chk("early enable", en, 1'b0);
    pat = 6'h01;
    wait_en(1'b1);
    chk("restart delay", n, 2 * MSC + 2);
    $display("delay test done");
    sys_rst = 1;
    @(negedge core_clk);
    sys_rst = 0;
    {ma, mb, mc} = {8'h00, 8'h80, 8'h00};
    chk("reset enable", en, 1'b0);
    rd(8'h11);
    $display("reset test done");
    final_report();
  end
endmodule
bind ceg_top ceg_checker u_chk (.*);
`default_nettype wire
